// ---- pkg/serial_port_pkg.sv ----
// Purpose: Shared constants and types for the asynchronous serial port
// Assumes: APB word addressing, byte address is four times a register index
// Notes:   Register indices are kept as printed and scaled by four on the bus
package serial_port_pkg;

	// Register indices, byte address = index * 4
	localparam logic [9:0] CTRL_IDX       = 10'h000;
	localparam logic [9:0] BUF_IDX        = 10'h001;
	localparam logic [9:0] POWER_IDX      = 10'h002;
	localparam logic [9:0] SLAVE_ADDR_IDX = 10'h0a9;
	localparam logic [9:0] SLAVE_MASK_IDX = 10'h0b9;

	// Reset values
	localparam logic [7:0] SLAVE_ADDR_RST = 8'h00;
	localparam logic [7:0] SLAVE_MASK_RST = 8'h00;
	localparam logic [7:0] BYTE_RST       = 8'h00;

	// Serial control register field positions
	localparam int CTRL_MODE_HI_BIT = 7;
	localparam int CTRL_MODE_LO_BIT = 6;
	localparam int CTRL_AME_BIT     = 5;
	localparam int CTRL_REN_BIT     = 4;
	localparam int CTRL_TB8_BIT     = 3;
	localparam int CTRL_RB8_BIT     = 2;
	localparam int CTRL_TI_BIT      = 1;
	localparam int CTRL_RI_BIT      = 0;

	// Power control register field positions
	localparam int POWER_DOUBLER_BIT = 7;
	localparam int POWER_FESEL_BIT   = 6;

	// Bit timing
	localparam logic [3:0] LAST_SLICE  = 4'hf;
	localparam logic [3:0] VOTE_SLICE0 = 4'h7;
	localparam logic [3:0] VOTE_SLICE1 = 4'h8;
	localparam logic [3:0] VOTE_SLICE2 = 4'h9;
	localparam logic [1:0] OSC_DIV_FAST = 2'h1;
	localparam logic [1:0] OSC_DIV_SLOW = 2'h3;
	localparam logic [1:0] TMR_DIV_FAST = 2'h0;
	localparam logic [1:0] TMR_DIV_SLOW = 2'h1;

	// Frame lengths in bit periods
	localparam logic [3:0] FRAME_BITS_10 = 4'ha;
	localparam logic [3:0] FRAME_BITS_11 = 4'hb;
	localparam logic [3:0] LAST_IDX_10   = 4'h9;
	localparam logic [3:0] LAST_IDX_11   = 4'ha;

	typedef enum logic [1:0] {
		MODE_SHIFT,
		MODE_ASYNC10_TIMER,
		MODE_ASYNC11_OSC,
		MODE_ASYNC11_TIMER
	} serial_mode_t;

	// Serial control register as software sees it, bit 7 muxed separately
	typedef struct packed {
		logic mode_field_high;
		logic mode_field_low;
		logic address_match_enable;
		logic receive_enable;
		logic transmit_ninth_bit;
		logic received_ninth_bit;
		logic transmit_done_flag;
		logic receive_done_flag;
	} serial_ctrl_t;

	localparam serial_ctrl_t CTRL_RST = 8'h00;

endpackage

// ---- hw/serial_port.sv ----
// Purpose: Asynchronous full-duplex serial port with address recognition
// Assumes: APB slave, pclk acts as the oscillator, timer_overflow is a pulse
// Notes:   Synchronous shift mode is accepted as a mode value but idles
//
// Functional notes
// - Two-bit mode field picks shift, 10-bit timer, 11-bit osc, 11-bit timer.
// - 10-bit mode bit rate is timer overflow over 16 or 32 by doubler.
// - Buffer write waits for next divided rollover; one bit per rollover.
// - 10-bit mode sends stop and sets transmit done at tenth rollover.
// - Receive only with receive enable; line sampled at sixteen times bit rate.
// - Falling edge on input resets the receive divider at once.
// - Each bit is a majority of samples at slices eight, nine, ten.
// - Start bit voted one abandons the frame and resumes edge search.
// - 10-bit accept needs receive done clear and matching off or stop one.
// - Edge search resumes from the middle of the stop bit.
// - 11-bit frame is start, eight data LSB first, ninth bit, stop.
// - Fixed-rate 11-bit mode runs at oscillator over 32 or 64.
// - Fixed-rate 11-bit transmit done rises at eleventh rollover.
// - 11-bit accept needs receive done clear and matching off or ninth one.
// - Variable-rate 11-bit mode equals fixed one but uses timer rate.
// - Missing valid stop bit sets the frame error flag.
// - Control bit 7 shows frame error if select set, else upper mode bit.
// - Frame error set by hardware only, cleared by software with select high.
// - With matching on in 11-bit modes, byte must hit given or broadcast.
// - Given address compares only slave address bits whose mask bit is one.
// - Broadcast address is address OR mask, zeros are don't care.
// - Slave address and mask reset to zero so every address matches.
//
// The implementer's own choice: the APB interface to the registers.
module serial_port (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        timer_overflow,
	input  wire logic        rxd,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             txd
);

	// Register state
	serial_port_pkg::serial_ctrl_t ctrl_r;
	serial_port_pkg::serial_ctrl_t ctrl_nxt;
	logic        frame_error_flag_r;
	logic        frame_error_flag_nxt;
	logic        baud_doubler_bit_r;
	logic        frame_error_select_r;
	logic [7:0]  slave_address_r;
	logic [7:0]  slave_address_mask_r;
	logic [7:0]  rx_buffer_r;

	// Bus state
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;

	// Bit timing state
	logic [1:0]  pre_cnt_r;
	logic        tick_r;
	logic [3:0]  tx_div_r;

	// Transmit state
	logic        tx_busy_r;
	logic [10:0] tx_shift_r;
	logic [3:0]  tx_left_r;
	logic        txd_r;

	// Receive state
	logic        rx_active_r;
	logic [3:0]  rx_div_r;
	logic [3:0]  rx_idx_r;
	logic [8:0]  rx_shift_r;
	logic        vote_a_r;
	logic        vote_b_r;
	logic        rxd_prev_r;

	// Bus decode
	wire         access      = psel & penable;
	wire         first_acc   = access & ~pready_r;
	wire         commit      = access & pready_r;
	wire  [9:0]  word_idx    = paddr[11:2];
	wire         hit_ctrl    = word_idx == serial_port_pkg::CTRL_IDX;
	wire         hit_buf     = word_idx == serial_port_pkg::BUF_IDX;
	wire         hit_power   = word_idx == serial_port_pkg::POWER_IDX;
	wire         hit_slave_address   = word_idx == serial_port_pkg::SLAVE_ADDR_IDX;
	wire         hit_smask   = word_idx == serial_port_pkg::SLAVE_MASK_IDX;
	wire         mapped      = hit_ctrl | hit_buf | hit_power | hit_slave_address | hit_smask;
	wire         wr_ctrl     = commit & pwrite & hit_ctrl;
	wire         wr_buf      = commit & pwrite & hit_buf;
	wire         wr_power    = commit & pwrite & hit_power;
	wire         wr_slave_address    = commit & pwrite & hit_slave_address;
	wire         wr_smask    = commit & pwrite & hit_smask;

	// Mode decode
	wire  [1:0]  mode        = {ctrl_r.mode_field_high, ctrl_r.mode_field_low};
	wire         is_async    = mode != 2'(serial_port_pkg::MODE_SHIFT);
	wire         is_11bit    = mode[1];
	wire         osc_rate    = mode == 2'(serial_port_pkg::MODE_ASYNC11_OSC);

	// Prescaler to the 16x sample tick; timer modes count overflows instead
	wire         src_event   = osc_rate ? 1'b1 : timer_overflow;
	wire  [1:0]  osc_div     = baud_doubler_bit_r ? serial_port_pkg::OSC_DIV_FAST
	                                              : serial_port_pkg::OSC_DIV_SLOW;
	wire  [1:0]  tmr_div     = baud_doubler_bit_r ? serial_port_pkg::TMR_DIV_FAST
	                                              : serial_port_pkg::TMR_DIV_SLOW;
	wire  [1:0]  pre_top     = osc_rate ? osc_div : tmr_div;
	wire         pre_wrap    = src_event & (pre_cnt_r == pre_top);

	// Transmit timing: rollover of the divided clock paces each bit
	wire         tx_roll     = tick_r & (tx_div_r == serial_port_pkg::LAST_SLICE);
	wire         tx_load     = wr_buf & is_async;
	wire         ninth_out   = is_11bit ? ctrl_r.transmit_ninth_bit : 1'b1;
	wire  [10:0] tx_frame    = {1'b1, ninth_out, pwdata[7:0], 1'b0};
	wire  [3:0]  tx_bits     = is_11bit ? serial_port_pkg::FRAME_BITS_11
	                                    : serial_port_pkg::FRAME_BITS_10;
	wire         tx_step     = tx_roll & tx_busy_r & ~tx_load;
	wire         ti_set      = tx_step & (tx_left_r == 4'h1);

	// Receive: edge search, voting and frame end
	wire         rx_fall     = tick_r & ctrl_r.receive_enable & is_async & ~rx_active_r
	                           & rxd_prev_r & ~rxd;
	wire         rx_run      = tick_r & rx_active_r;
	wire         vote_point  = rx_run & (rx_div_r == serial_port_pkg::VOTE_SLICE2);
	wire         bit_vote    = (vote_a_r & vote_b_r) | (vote_a_r & rxd) | (vote_b_r & rxd);
	wire  [3:0]  last_idx    = is_11bit ? serial_port_pkg::LAST_IDX_11
	                                    : serial_port_pkg::LAST_IDX_10;
	wire         rx_abort    = vote_point & (rx_idx_r == 4'h0) & bit_vote;
	wire         rx_end      = vote_point & (rx_idx_r == last_idx);
	wire  [7:0]  rx_data     = is_11bit ? rx_shift_r[7:0] : rx_shift_r[8:1];
	wire         rx_ninth    = is_11bit ? rx_shift_r[8] : bit_vote;

	// Address recognition
	wire  [7:0]  bcast       = slave_address_r | slave_address_mask_r;
	wire         given_hit   = ((rx_data ^ slave_address_r) & slave_address_mask_r) == 8'h00;
	wire         bcast_hit   = (~rx_data & bcast) == 8'h00;
	wire         addr_ok     = is_11bit ? (rx_ninth & (given_hit | bcast_hit))
	                                    : rx_ninth;
	wire         rx_accept   = rx_end & ~ctrl_r.receive_done_flag
	                           & (~ctrl_r.address_match_enable | addr_ok);
	wire         fe_set      = rx_end & ~bit_vote;

	// Read view of the control register, bit 7 is shared
	wire         ctrl_top    = frame_error_select_r ? frame_error_flag_r
	                                                : ctrl_r.mode_field_high;
	wire  [7:0]  ctrl_view   = {ctrl_top, ctrl_r[6:0]};
	wire  [7:0]  power_view  = {baud_doubler_bit_r, frame_error_select_r, 6'h00};
	wire  [7:0]  read_byte   = hit_ctrl  ? ctrl_view :
	                           hit_buf   ? rx_buffer_r :
	                           hit_power ? power_view :
	                           hit_slave_address ? slave_address_r :
	                           hit_smask ? slave_address_mask_r : 8'h00;

	// Control next value: hardware sets win over a software write in the same cycle
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = pwdata[7:0];
			if (frame_error_select_r) begin
				ctrl_nxt.mode_field_high = ctrl_r.mode_field_high;
			end
		end
		if (rx_accept) begin
			ctrl_nxt.received_ninth_bit = rx_ninth;
			ctrl_nxt.receive_done_flag  = 1'b1;
		end
		if (ti_set) begin
			ctrl_nxt.transmit_done_flag = 1'b1;
		end
	end

	// Frame error is only cleared through bit 7 while the select bit is high
	assign frame_error_flag_nxt = fe_set |
		(frame_error_flag_r & ~(wr_ctrl & frame_error_select_r & ~pwdata[7]));

	// Registers software writes, plus the receive buffer loaded on accept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r               <= serial_port_pkg::CTRL_RST;
			frame_error_flag_r   <= 1'b0;
			baud_doubler_bit_r   <= 1'b0;
			frame_error_select_r <= 1'b0;
			slave_address_r      <= serial_port_pkg::SLAVE_ADDR_RST;
			slave_address_mask_r <= serial_port_pkg::SLAVE_MASK_RST;
			rx_buffer_r          <= serial_port_pkg::BYTE_RST;
		end else begin
			ctrl_r             <= ctrl_nxt;
			frame_error_flag_r <= frame_error_flag_nxt;
			if (wr_power) begin
				baud_doubler_bit_r   <= pwdata[serial_port_pkg::POWER_DOUBLER_BIT];
				frame_error_select_r <= pwdata[serial_port_pkg::POWER_FESEL_BIT];
			end
			if (wr_slave_address) begin
				slave_address_r <= pwdata[7:0];
			end
			if (wr_smask) begin
				slave_address_mask_r <= pwdata[7:0];
			end
			if (rx_accept) begin
				rx_buffer_r <= rx_data;
			end
		end
	end

	// APB: one wait state so read data and pready both leave flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= first_acc;
			pslverr_r <= first_acc & ~mapped;
			if (first_acc) begin
				prdata_r <= {24'h00_0000, read_byte};
			end
		end
	end

	// Sample tick prescaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_r <= 2'h0;
			tick_r    <= 1'b0;
		end else begin
			tick_r <= pre_wrap;
			if (pre_wrap) begin
				pre_cnt_r <= 2'h0;
			end else if (src_event) begin
				pre_cnt_r <= pre_cnt_r + 2'h1;
			end
		end
	end

	// Free running transmit divider, sixteen ticks per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_div_r <= 4'h0;
		end else if (tick_r) begin
			tx_div_r <= tx_div_r + 4'h1;
		end
	end

	// Transmitter: the write only loads; bits leave on rollovers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy_r  <= 1'b0;
			tx_shift_r <= 11'h7ff;
			tx_left_r  <= 4'h0;
			txd_r      <= 1'b1;
		end else if (tx_load) begin
			tx_busy_r  <= 1'b1;
			tx_shift_r <= tx_frame;
			tx_left_r  <= tx_bits;
		end else if (tx_step) begin
			txd_r      <= tx_shift_r[0];
			tx_shift_r <= {1'b1, tx_shift_r[10:1]};
			tx_left_r  <= tx_left_r - 4'h1;
			tx_busy_r  <= tx_left_r != 4'h1;
		end
	end

	// Receiver: divider restarts on the edge, votes at slices eight to ten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_prev_r  <= 1'b1;
			rx_active_r <= 1'b0;
			rx_div_r    <= 4'h0;
			rx_idx_r    <= 4'h0;
			rx_shift_r  <= 9'h000;
			vote_a_r    <= 1'b0;
			vote_b_r    <= 1'b0;
		end else begin
			if (tick_r) begin
				rxd_prev_r <= rxd;
			end
			if (rx_fall) begin
				rx_active_r <= 1'b1;
				rx_div_r    <= 4'h0;
				rx_idx_r    <= 4'h0;
			end else if (rx_run) begin
				rx_div_r <= rx_div_r + 4'h1;
				if (rx_div_r == serial_port_pkg::VOTE_SLICE0) begin
					vote_a_r <= rxd;
				end
				if (rx_div_r == serial_port_pkg::VOTE_SLICE1) begin
					vote_b_r <= rxd;
				end
				if (rx_abort || rx_end) begin
					rx_active_r <= 1'b0;
				end else if (vote_point) begin
					rx_idx_r <= rx_idx_r + 4'h1;
					if (rx_idx_r != 4'h0) begin
						rx_shift_r <= {bit_vote, rx_shift_r[8:1]};
					end
				end
			end
		end
	end

	// Outputs straight from flip-flops
	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign txd     = txd_r;

endmodule

// ---- tb/serial_port_assertions.sv ----
// Purpose: Concurrent checks on the serial port's bus and line pins
// Assumes: Shadows of written values tell what a read-back must return
// Notes:   Frame content is judged by the bench, not here
module serial_port_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        timer_overflow,
	input wire logic        rxd,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        txd
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Decode of the transfer in flight
	wire logic [9:0] idx = paddr[11:2];
	wire logic       acc = psel && penable && pready;
	wire logic       wr  = acc && pwrite;
	wire logic       rd  = acc && !pwrite;
	wire logic       map = idx == serial_port_pkg::CTRL_IDX || idx == serial_port_pkg::BUF_IDX
		|| idx == serial_port_pkg::POWER_IDX || idx == serial_port_pkg::SLAVE_ADDR_IDX
		|| idx == serial_port_pkg::SLAVE_MASK_IDX;
	logic [7:0] addr_r;
	logic [7:0] mask_r;
	logic       fesel_r;
	logic       mode_hi_r;
	// Mode bit only lands while bit 7 is not the error view
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{addr_r, mask_r, fesel_r, mode_hi_r} <= 18'h00000;
		end else if (wr) begin
			if (idx == serial_port_pkg::SLAVE_ADDR_IDX) addr_r <= pwdata[7:0];
			if (idx == serial_port_pkg::SLAVE_MASK_IDX) mask_r <= pwdata[7:0];
			if (idx == serial_port_pkg::POWER_IDX) fesel_r <= pwdata[6];
			if (idx == serial_port_pkg::CTRL_IDX && !fesel_r) mode_hi_r <= pwdata[7];
		end
	end
	property p_ready_follows; psel && penable && !pready |=> pready; endproperty
	a_ready_follows: assert property (p_ready_follows) else $error("pready late");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
	property p_err_decode; pready |-> pslverr == !map; endproperty
	a_err_decode: assert property (p_err_decode) else $error("bad pslverr");
	property p_err_alone; pslverr |-> pready; endproperty
	a_err_alone: assert property (p_err_alone) else $error("pslverr without pready");
	property p_upper_zero; rd |-> prdata[31:8] == 24'h0 && (map || prdata[7:0] == 8'h00); endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("read data not clear");
	property p_addr_back; rd && idx == serial_port_pkg::SLAVE_ADDR_IDX |-> prdata[7:0] == addr_r;
	endproperty
	a_addr_back: assert property (p_addr_back) else $error("address readback");
	property p_mask_back; rd && idx == serial_port_pkg::SLAVE_MASK_IDX |-> prdata[7:0] == mask_r;
	endproperty
	a_mask_back: assert property (p_mask_back) else $error("mask readback");
	property p_mode_view;
		rd && idx == serial_port_pkg::CTRL_IDX && !fesel_r |-> prdata[7] == mode_hi_r;
	endproperty
	a_mode_view: assert property (p_mode_view) else $error("bit 7 view");
	property p_tx_deferred; wr && idx == serial_port_pkg::BUF_IDX && txd |=> txd; endproperty
	a_tx_deferred: assert property (p_tx_deferred) else $error("start bit too early");
	c_buf_write: cover property (wr && idx == serial_port_pkg::BUF_IDX);
	c_rx_done: cover property (rd && idx == serial_port_pkg::CTRL_IDX && prdata[0]);
	c_refused: cover property (pslverr);
endmodule
bind serial_port serial_port_checker u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .timer_overflow(timer_overflow), .rxd(rxd),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd)
);

// ---- tb/remote_node.sv ----
// Purpose: Remote serial node driving rxd and listening on txd
// Assumes: Bench sets the bit period in pclk cycles before each frame
// Notes:   rxd idles high as if pulled up
module remote_node (
	input  wire logic pclk,
	input  wire logic txd,
	output logic      rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	int bit_cycles = 32;
	initial rxd = 1'b1;
	// One frame LSB first; an edge passes after release so calls never collide
	task automatic send(input logic [10:0] f, input int nbits);
		for (int i = 0; i < nbits; i++) begin
			rxd <= f[i];
			repeat (bit_cycles) @(posedge pclk);
		end
		rxd <= 1'b1;
		@(posedge pclk);
	endtask
	// Mid-bit sampling after the start edge
	task automatic capture(input int nbits, output logic [10:0] f);
		f = 11'h000;
		@(negedge txd);
		repeat (bit_cycles / 2) @(posedge pclk);
		for (int i = 0; i < nbits; i++) begin
			f[i] = txd;
			repeat (bit_cycles) @(posedge pclk);
		end
	endtask
endmodule

// ---- tb/async_serial_port_addr_match_tb.sv ----
// Purpose: Self-checking bench for the serial port with address recognition
// Assumes: An overflow every two pclk cycles, so a bit lasts 32 or 64 cycles
// Notes:   Random bytes from a fixed seed; corner cases placed by hand
module async_serial_port_addr_match_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        timer_overflow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	wire logic   rxd, txd, pready, pslverr;
	wire logic [31:0] prdata;
	logic [31:0] rdata;
	logic [10:0] fr;
	logic [7:0]  b, sa, sm;
	logic [1:0]  md;
	logic        nin, dbl;
	int          nb;
	int          errors = 0;
	int          n_compared = 0;
	int          seed = 32'hfc92eb78;
	always #2.5 pclk = ~pclk;
	// Overflow every other cycle keeps the timer and oscillator rates equal
	always @(posedge pclk) timer_overflow <= ~timer_overflow;
	serial_port u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .timer_overflow(timer_overflow), .rxd(rxd),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd)
	);
	remote_node u_peer (.pclk(pclk), .txd(txd), .rxd(rxd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One transfer; an idle edge follows so the next setup never overlaps
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(32'(pready), 32'h1);
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic ctl(input logic [7:0] d);
		apb(1'b1, serial_port_pkg::CTRL_IDX, d);
	endtask
	task automatic pwr(input logic [7:0] d);
		apb(1'b1, serial_port_pkg::POWER_IDX, d);
	endtask
	function automatic logic [10:0] frame(input logic [7:0] d, input logic n9, input int nbits);
		return (nbits == 10) ? {2'b01, d, 1'b0} : {1'b1, n9, d, 1'b0};
	endfunction
	// Broadcast is address OR mask; zeros there are don't care
	function automatic logic hit(input logic [7:0] v, input logic [7:0] a, input logic [7:0] m);
		return ((v ^ a) & m) == 8'h00 || ((v ^ (a | m)) & (a | m)) == 8'h00;
	endfunction
	// Far node sends a frame, then control is read back
	task automatic rx(input logic [7:0] d, input logic n9, input logic stop, input int nbits);
		logic [10:0] f;
		f = frame(d, n9, nbits);
		f[nbits-1] = stop;
		u_peer.send(f, nbits);
		apb(1'b0, serial_port_pkg::CTRL_IDX, 8'h00);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, serial_port_pkg::SLAVE_ADDR_IDX, 8'h00);
		chk(rdata, 32'h0);
		apb(1'b0, serial_port_pkg::SLAVE_MASK_IDX, 8'h00);
		chk(rdata, 32'h0);
		apb(1'b1, 10'h3ff, 8'hff);
		apb(1'b0, 10'h3ff, 8'h00);
		chk(rdata, 32'h0);
		// Each async mode at both rates, one frame each way
		for (int k = 0; k < 6; k++) begin
			md = 2'(1 + k % 3);
			dbl = (k < 3);
			nb = (md == 2'h1) ? 10 : 11;
			b = 8'($random(seed));
			nin = 1'($random(seed));
			u_peer.bit_cycles = dbl ? 32 : 64;
			pwr({dbl, 7'h00});
			ctl({md, 2'b01, nin, 3'b000});
			fork
				u_peer.capture(nb, fr);
				apb(1'b1, serial_port_pkg::BUF_IDX, b);
			join
			chk(32'(fr), 32'(frame(b, nin, nb)));
			apb(1'b0, serial_port_pkg::CTRL_IDX, 8'h00);
			chk(32'(rdata[1]), 32'h1);
			rx(~b, ~nin, 1'b1, nb);
			chk(32'(rdata[2:0]), {29'h0, (nb == 10) | ~nin, 2'b11});
			apb(1'b0, serial_port_pkg::BUF_IDX, 8'h00);
			chk(rdata, {24'h0, ~b});
		end
		u_peer.bit_cycles = 32;
		sa = 8'($random(seed));
		sm = 8'($random(seed));
		pwr(8'h80);
		apb(1'b1, serial_port_pkg::SLAVE_ADDR_IDX, sa);
		apb(1'b1, serial_port_pkg::SLAVE_MASK_IDX, sm);
		ctl(8'hf0);
		// Given, broadcast, a data byte, the address XOR mask, then random
		for (int k = 0; k < 8; k++) begin
			b = (k == 0) ? sa : (k == 1) ? (sa | sm) : (k == 3) ? (sa ^ sm) : 8'($random(seed));
			nin = (k != 2);
			rx(b, nin, 1'b1, 11);
			chk(32'(rdata[0]), 32'(nin & hit(b, sa, sm)));
			ctl(8'hf0);
		end
		ctl(8'hd0);
		rx(~sa, 1'b0, 1'b1, 11);
		chk(32'(rdata[1:0]), 32'h1);
		// Bad stop with matching on: flagged, not taken; good frame keeps flag
		ctl(8'h70);
		pwr(8'hc0);
		rx(b, 1'b0, 1'b0, 10);
		chk(32'({rdata[7], rdata[0]}), 32'h2);
		ctl(8'hd0);
		rx(b, 1'b0, 1'b1, 10);
		chk(32'({rdata[7], rdata[0]}), 32'h3);
		pwr(8'h80);
		apb(1'b0, serial_port_pkg::CTRL_IDX, 8'h00);
		chk(32'(rdata[7]), 32'h0);
		pwr(8'hc0);
		ctl(8'h50);
		apb(1'b0, serial_port_pkg::CTRL_IDX, 8'h00);
		chk(32'(rdata[7]), 32'h0);
		// Start pulse too short for the vote, then an idle frame time
		u_peer.bit_cycles = 4;
		u_peer.send(11'h000, 1);
		u_peer.bit_cycles = 32;
		u_peer.send(11'h3ff, 10);
		apb(1'b0, serial_port_pkg::CTRL_IDX, 8'h00);
		chk(32'(rdata[0]), 32'h0);
		ctl(8'h40);
		rx(b, 1'b0, 1'b1, 10);
		chk(32'(rdata[0]), 32'h0);
		print_verdict();
	end
	// Run needs about 11k cycles; 200 us leaves ample margin
	initial begin
		#200us;
		errors++;
		print_verdict();
	end
	task automatic print_verdict();
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
endmodule
